//--- rtl/opstate_pkg.sv
/*
  Shared types and constants for the operating-state sequencer.
  Assumes a single 40 MHz processor clock and an asynchronous active-high reset.
*/
package opstate_pkg;

  // Clock and reset timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int RESET_ENTRY_CYCLES = 5;

  // Address and data widths
  localparam int ADDR_W = 16;
  localparam int SEG_W = 7;
  localparam int WORD_W = 16;

  // Flag-and-control word bit positions
  localparam int FLAGS_SYS_POS = 14;
  localparam int FLAGS_SEG_POS = 15;
  localparam int FLAGS_EPU_POS = 13;

  // Refresh interval
  localparam logic [7:0] REFRESH_INTERVAL = 8'h3F;

  // Reset values of program status
  localparam logic [WORD_W-1:0] FLAGS_RESET = 16'h4000;
  localparam logic [ADDR_W-1:0] PC_RESET = 16'h0000;
  localparam logic [SEG_W-1:0] SEG_RESET = 7'h00;

  // Vector addresses and status word loaded on exception entry
  localparam logic [ADDR_W-1:0] TRAP_PC = 16'h0010;
  localparam logic [ADDR_W-1:0] INT_PC = 16'h0020;
  localparam logic [WORD_W-1:0] EXC_FLAGS = 16'h4000;

  // Instruction classes reported by the decoder
  typedef enum logic [2:0] {
    CLS_PLAIN,
    CLS_BRANCH,
    CLS_PRIV,
    CLS_EXT,
    CLS_LOAD_PS
  } instr_class_e;

  // Operating states
  typedef enum logic [1:0] {
    OP_RESET,
    OP_RUN,
    OP_STOP,
    OP_DISC
  } op_state_e;

  // Running-state micro steps
  typedef enum logic [2:0] {
    ST_FETCH,
    ST_EXEC,
    ST_SAVE_PC,
    ST_SAVE_FLAGS,
    ST_LOAD
  } run_step_e;

  // Bus cycle kinds
  typedef enum logic [1:0] {
    CYC_NONE,
    CYC_FETCH,
    CYC_REFRESH,
    CYC_WRITE
  } cyc_kind_e;

  // One memory cycle issued by the sequencer
  typedef struct packed {
    cyc_kind_e kind;
    logic [SEG_W-1:0] segmented_mode_bit;
    logic [ADDR_W-1:0] offset;
    logic [WORD_W-1:0] wdata;
  } bus_cycle_s;

  // Word delivered by the decoder for the instruction just fetched
  typedef struct packed {
    instr_class_e cls;
    logic last_word;
    logic [ADDR_W-1:0] target;
    logic [WORD_W-1:0] new_flags;
  } decode_s;

endpackage : opstate_pkg

//--- rtl/bus_cycle_timer.sv
/*
  Two-phase bus cycle timer: segment phase then offset phase.
  Assumes start is a single-cycle pulse from the sequencer on the same clock.
*/
`timescale 1ns/1ps
module bus_cycle_timer
  import opstate_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Control
  input wire logic start,
  // Status
  output logic busy,
  output logic seg_phase,
  output logic done
);

  typedef struct packed {
    logic [1:0] phase;
    logic done;
  } timer_s;

  timer_s st_q;
  timer_s st_d;

  // Segment phase, offset phase, then complete
  always_comb begin
    st_d = st_q;
    st_d.done = 1'b0;
    case (st_q.phase)
      2'd0: begin
        if (start) begin
          st_d.phase = 2'd1;
        end
      end
      2'd1: st_d.phase = 2'd2;
      2'd2: begin
        st_d.phase = 2'd0;
        st_d.done = 1'b1;
      end
      default: st_d.phase = 2'd0;
    endcase
  end

  // State register
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign busy = (st_q.phase != 2'd0);
  assign seg_phase = (st_q.phase == 2'd1);
  assign done = st_q.done;

endmodule : bus_cycle_timer

//--- rtl/cpu_operating_state_control.sv
/*
  Operating-state sequencer: running, stop/refresh and bus-disconnect,
  plus the fetch/execute loop with exception entry.
  Assumes an external decoder that classifies each fetched word in the same
  cycle, and bus-request and suspend inputs that come from outside the clock.
*/
// How it works
// - Exactly one of three operating states
// - Suspend or refresh due enters stop/refresh
// - Stop/refresh issues only back-to-back refreshes
// - Leave stop when suspend low, none pending
// - Grant asserted before entering bus-disconnect (from reset, grant and disconnect come in the same cycle)
// - Disconnect floats bus outputs, no activity
// - Request release leaves bus-disconnect
// - Bus request outranks all other transitions
// - Reset reaches nonoperational state within five cycles
// - Reset release picks state from inputs
// - Running repeats fetch then execute
// - Ordinary instruction advances past last word
// - Branch-type instructions load the target
// - Fetch next word overlaps current execution
// - Check traps and interrupts between instructions
// - Exception saves status, loads fresh status
// - Mode comes from three control bits
// - Segment number driven before the offset
// - Segmented mode uses 23-bit addresses
// - Normal mode refuses privileged instructions
// - Missing extended unit traps extended instructions
`timescale 1ns/1ps
module cpu_operating_state_control
  import opstate_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // External master and suspend control
  input wire logic bus_request_in,
  input wire logic suspend_in,
  output logic bus_grant_out,
  // Exception requests
  input wire logic irq_in,
  input wire logic irq_mask_in,
  // Decoder
  input wire decode_s dec_in,
  // Memory bus
  output bus_cycle_s bus_out,
  output logic bus_oe,
  output logic seg_early,
  // Status
  output op_state_e op_state,
  output logic [WORD_W-1:0] flag_control_word,
  output logic [ADDR_W-1:0] pc_out,
  output logic nonop_out
);

  typedef struct packed {
    logic [1:0] req_sync;
    logic [1:0] sus_sync;
    op_state_e state;
    run_step_e step;
    logic [ADDR_W-1:0] pc;
    logic [SEG_W-1:0] pc_seg;
    logic [WORD_W-1:0] flags;
    logic [ADDR_W-1:0] saved_pc;
    logic [ADDR_W-1:0] vec_pc;
    logic [7:0] ref_cnt;
    logic ref_due;
    logic grant;
    logic oe;
    logic seg_early;
    logic look_ahead;
    bus_cycle_s cyc;
    logic cyc_start;
    logic [1:0] settle;
    logic nonop;
  } ctl_s;

  ctl_s s_q;
  ctl_s s_d;
  logic bt_busy;
  logic bt_seg;
  logic bt_done;
  logic req_s;
  logic sus_s;
  logic boundary;
  logic exc_pending;
  logic trap_now;

  // Bus-cycle phase timer
  bus_cycle_timer u_timer (
    .clk_sys(clk_sys),
    .reset(reset),
    .start(s_q.cyc_start),
    .busy(bt_busy),
    .seg_phase(bt_seg),
    .done(bt_done)
  );

  // Address of the next fetch, cut to the active mode width
  function automatic logic [SEG_W-1:0] fetch_seg(input logic [WORD_W-1:0] flags, input logic [SEG_W-1:0] segmented_mode_bit);
    fetch_seg = flags[FLAGS_SEG_POS] ? segmented_mode_bit : SEG_RESET;
  endfunction : fetch_seg

  // Pack a bus cycle
  function automatic bus_cycle_s make_cyc(input cyc_kind_e k, input logic [SEG_W-1:0] sg,
                                          input logic [ADDR_W-1:0] off, input logic [WORD_W-1:0] wd);
    make_cyc.kind = k;
    make_cyc.segmented_mode_bit = sg;
    make_cyc.offset = off;
    make_cyc.wdata = wd;
  endfunction : make_cyc

  // Instructions whose target replaces the sequential counter
  function automatic logic takes_target(input instr_class_e cls);
    takes_target = (cls == CLS_BRANCH) || (cls == CLS_LOAD_PS);
  endfunction : takes_target

  // Synchronised versions of the pin inputs
  assign req_s = s_q.req_sync[1];
  assign sus_s = s_q.sus_sync[1];
  // Transitions only between bus cycles
  assign boundary = !bt_busy && !s_q.cyc_start;
  assign exc_pending = irq_in && !irq_mask_in;
  // Privileged in normal mode, or extended with no unit, traps
  assign trap_now = ((dec_in.cls == CLS_PRIV) && !s_q.flags[FLAGS_SYS_POS]) ||
                    ((dec_in.cls == CLS_EXT) && !s_q.flags[FLAGS_EPU_POS]);

  // Next-state logic
  always_comb begin
    s_d = s_q;
    s_d.req_sync = {s_q.req_sync[0], bus_request_in};
    s_d.sus_sync = {s_q.sus_sync[0], suspend_in};
    s_d.cyc_start = 1'b0;
    s_d.seg_early = bt_seg && s_q.flags[FLAGS_SEG_POS];
    // Refresh counter runs outside disconnect and reset
    if (s_q.state != OP_DISC && s_q.state != OP_RESET) begin
      if (s_q.ref_cnt == REFRESH_INTERVAL) begin
        s_d.ref_cnt = '0;
        s_d.ref_due = 1'b1;
      end else begin
        s_d.ref_cnt = s_q.ref_cnt + 8'h01;
      end
    end
    case (s_q.state)
      OP_RESET: begin
        // Wait until both sync stages hold post-reset pin levels, then pick the state
        s_d.settle = {s_q.settle[0], 1'b1};
        if (!s_q.settle[1]) begin
          s_d.state = OP_RESET;
        end else if (req_s) begin
          s_d.grant = 1'b1;
          s_d.state = OP_DISC;
          s_d.oe = 1'b0;
        end else if (sus_s) begin
          s_d.state = OP_STOP;
          s_d.oe = 1'b1;
        end else begin
          s_d.state = OP_RUN;
          s_d.oe = 1'b1;
        end
      end
      OP_RUN, OP_STOP: begin
        if (boundary) begin
          if (req_s) begin
            // Grant first, float bus next cycle
            if (!s_q.grant) begin
              s_d.grant = 1'b1;
            end else begin
              s_d.state = OP_DISC;
              s_d.oe = 1'b0;
            end
          end else if (sus_s || s_q.ref_due) begin
            s_d.state = OP_STOP;
            s_d.ref_due = (s_q.ref_cnt == REFRESH_INTERVAL); // Set wins over clear
            s_d.cyc = make_cyc(CYC_REFRESH, SEG_RESET, {8'h00, s_q.ref_cnt}, '0);
            s_d.cyc_start = 1'b1;
          end else if (s_q.state == OP_STOP) begin
            s_d.state = OP_RUN;
          end else begin
            // Running micro sequence
            case (s_q.step)
              ST_FETCH: begin
                s_d.cyc = make_cyc(CYC_FETCH, fetch_seg(s_q.flags, s_q.pc_seg), s_q.pc, '0);
                s_d.cyc_start = 1'b1;
                s_d.step = ST_EXEC;
              end
              ST_EXEC: begin
                if (trap_now) begin
                  s_d.vec_pc = TRAP_PC;
                  s_d.saved_pc = s_q.pc;
                  s_d.step = ST_SAVE_PC;
                end else if (!dec_in.last_word) begin
                  s_d.pc = s_q.pc + 16'h0002;
                  s_d.step = ST_FETCH;
                end else begin
                  if (takes_target(dec_in.cls)) begin
                    s_d.pc = dec_in.target;
                    if (dec_in.cls == CLS_LOAD_PS) begin
                      s_d.flags = dec_in.new_flags;
                    end
                    s_d.look_ahead = 1'b0;
                  end else begin
                    s_d.pc = s_q.pc + 16'h0002;
                    s_d.look_ahead = 1'b1;
                  end
                  if (exc_pending) begin
                    s_d.vec_pc = INT_PC;
                    s_d.saved_pc = takes_target(dec_in.cls) ? dec_in.target : s_q.pc + 16'h0002;
                    s_d.step = ST_SAVE_PC;
                  end else if (!takes_target(dec_in.cls)) begin
                    // Next word fetched while this one retires
                    s_d.cyc = make_cyc(CYC_FETCH, fetch_seg(s_q.flags, s_q.pc_seg), s_q.pc + 16'h0002, '0);
                    s_d.cyc_start = 1'b1;
                    s_d.step = ST_EXEC;
                  end else begin
                    s_d.step = ST_FETCH;
                  end
                end
              end
              ST_SAVE_PC: begin
                s_d.cyc = make_cyc(CYC_WRITE, fetch_seg(s_q.flags, s_q.pc_seg), s_q.pc, s_q.saved_pc);
                s_d.cyc_start = 1'b1;
                s_d.step = ST_SAVE_FLAGS;
              end
              ST_SAVE_FLAGS: begin
                s_d.cyc = make_cyc(CYC_WRITE, fetch_seg(s_q.flags, s_q.pc_seg), s_q.pc, s_q.flags);
                s_d.cyc_start = 1'b1;
                s_d.step = ST_LOAD;
              end
              ST_LOAD: begin
                s_d.pc = s_q.vec_pc;
                s_d.flags = EXC_FLAGS;
                s_d.step = ST_FETCH;
              end
              default: s_d.step = ST_FETCH;
            endcase
          end
        end
      end
      OP_DISC: begin
        // No activity until the request is released
        if (!req_s) begin
          s_d.grant = 1'b0;
          s_d.oe = 1'b1;
          s_d.state = sus_s ? OP_STOP : OP_RUN;
        end
      end
      default: s_d.state = OP_RESET;
    endcase
    if (s_d.state == OP_DISC) begin
      s_d.cyc = make_cyc(CYC_NONE, SEG_RESET, PC_RESET, '0);
    end
    // Nonoperational flag kept in its own flip-flop
    s_d.nonop = (s_d.state == OP_RESET);
  end

  // State register; reset acts at once
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      s_q <= '0;
      s_q.state <= OP_RESET;
      s_q.step <= ST_FETCH;
      s_q.pc <= PC_RESET;
      s_q.pc_seg <= SEG_RESET;
      s_q.flags <= FLAGS_RESET;
      s_q.nonop <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from flip-flops
  assign bus_grant_out = s_q.grant;
  assign bus_out = s_q.cyc;
  assign bus_oe = s_q.oe;
  assign seg_early = s_q.seg_early;
  assign op_state = s_q.state;
  assign flag_control_word = s_q.flags;
  assign pc_out = s_q.pc;
  assign nonop_out = s_q.nonop;

  // Reset forces the nonoperational state within five cycles
  property p_reset_entry;
    @(posedge clk_sys) reset |-> ##[0:4] (op_state == OP_RESET);
  endproperty
  a_reset_entry: assert property (p_reset_entry) else $error("reset not reached");

  // Disconnect from run or stop only with grant already up
  property p_grant_first;
    @(posedge clk_sys) disable iff (reset)
      (op_state == OP_DISC && $past(op_state) != OP_DISC && $past(op_state) != OP_RESET) |-> $past(bus_grant_out);
  endproperty
  a_grant_first: assert property (p_grant_first) else $error("disconnect without prior grant");

  // Disconnect floats the bus
  property p_disc_float;
    @(posedge clk_sys) disable iff (reset) (op_state == OP_DISC) |-> (!bus_oe && bus_out.kind == CYC_NONE);
  endproperty
  a_disc_float: assert property (p_disc_float) else $error("bus driven in disconnect");

  // Stop state issues nothing but refreshes
  property p_stop_refresh;
    @(posedge clk_sys) disable iff (reset) (op_state == OP_STOP) |-> (bus_out.kind != CYC_FETCH && bus_out.kind != CYC_WRITE);
  endproperty
  a_stop_refresh: assert property (p_stop_refresh) else $error("non-refresh cycle in stop");

  // Request released leaves disconnect within the sync delay
  sequence s_released;
    !bus_request_in [*3];
  endsequence
  property p_leave_disc;
    @(posedge clk_sys) disable iff (reset) (op_state == OP_DISC) ##0 s_released |-> ##[0:1] (op_state != OP_DISC);
  endproperty
  a_leave_disc: assert property (p_leave_disc) else $error("disconnect held after release");

  // Suspend held reaches stop or disconnect within a bus cycle
  property p_suspend;
    @(posedge clk_sys) disable iff (reset) (op_state == OP_RUN && suspend_in) [*6] |=> (op_state != OP_RUN);
  endproperty
  a_suspend: assert property (p_suspend) else $error("suspend ignored");

  // Sequential advance by one word
  property p_pc_step;
    @(posedge clk_sys) disable iff (reset)
      (s_q.state == OP_RUN && s_q.step == ST_EXEC && boundary && !req_s && !sus_s && !s_q.ref_due && !trap_now &&
       dec_in.cls == CLS_PLAIN) |=> (pc_out == $past(pc_out) + 16'h0002);
  endproperty
  a_pc_step: assert property (p_pc_step) else $error("pc not advanced");

  // Exception entry lands on the vector with fresh status
  property p_exc_load;
    @(posedge clk_sys) disable iff (reset)
      (s_q.step == ST_LOAD && s_q.state == OP_RUN && boundary && !req_s && !sus_s && !s_q.ref_due)
      |=> (pc_out == $past(s_q.vec_pc) && flag_control_word == EXC_FLAGS);
  endproperty
  a_exc_load: assert property (p_exc_load) else $error("exception status not loaded");

  // Normal-mode privileged instruction traps
  property p_priv_trap;
    @(posedge clk_sys) disable iff (reset)
      (s_q.state == OP_RUN && s_q.step == ST_EXEC && boundary && !req_s && !sus_s && !s_q.ref_due && trap_now)
      |=> (s_q.step == ST_SAVE_PC && s_q.vec_pc == TRAP_PC);
  endproperty
  a_priv_trap: assert property (p_priv_trap) else $error("missed trap");

  // Stop ends once suspend and refresh are both clear
  property p_stop_exit;
    @(posedge clk_sys) disable iff (reset)
      (s_q.state == OP_STOP && boundary && !req_s && !sus_s && !s_q.ref_due) |=> (op_state == OP_RUN);
  endproperty
  a_stop_exit: assert property (p_stop_exit) else $error("stop held with no cause");

  // Granted request wins over suspend and refresh at the next boundary
  sequence s_granted_req;
    (s_q.state == OP_RUN || s_q.state == OP_STOP) && boundary && req_s && s_q.grant;
  endsequence
  property p_req_priority;
    @(posedge clk_sys) disable iff (reset) s_granted_req |=> (op_state == OP_DISC);
  endproperty
  a_req_priority: assert property (p_req_priority) else $error("request lost to another transition");

  // Grant stands for the whole disconnect
  property p_grant_hold;
    @(posedge clk_sys) disable iff (reset) (op_state == OP_DISC) |-> bus_grant_out;
  endproperty
  a_grant_hold: assert property (p_grant_hold) else $error("grant low in disconnect");

endmodule : cpu_operating_state_control

//--- verification/bus_master_model.sv
/*
  Model of the far side: an external bus master and the stop control logic.
  Assumes bench commands change just after a rising clock edge.
*/
`timescale 1ns/1ps
module bus_master_model (
  // Clock
  input wire logic clk_sys,
  // Commands from the bench
  input wire logic want_bus,
  input wire logic want_stop,
  input wire logic [7:0] hold_cycles,
  // Device side
  input wire logic bus_grant_out,
  output logic bus_request_in,
  output logic suspend_in,
  // Status to the bench
  output logic used_bus
);
  // Stop line follows the bench directly
  assign suspend_in = want_stop;
  // Request held until grant seen at an edge, kept for the hold span, then released
  initial begin
    bus_request_in = 1'b0;
    used_bus = 1'b0;
    forever begin
      @(posedge clk_sys);
      if (want_bus && !used_bus) begin
        #2 bus_request_in = 1'b1;
        do @(posedge clk_sys); while (bus_grant_out !== 1'b1);
        repeat (hold_cycles) @(posedge clk_sys);
        #2 bus_request_in = 1'b0;
        used_bus = 1'b1;
      end else if (!want_bus) begin
        #2 used_bus = 1'b0;
      end
    end
  end
endmodule : bus_master_model

//--- verification/tb_top.sv
/*
  Self-checking bench for the operating-state sequencer.
  Assumes the decoder answers for the word last fetched; the bench plays that decoder.
*/
`timescale 1ns/1ps
module tb_top
  import opstate_pkg::*;
;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic irq_in = 1'b0;
  logic irq_mask_in = 1'b0;
  logic want_bus = 1'b0;
  logic want_stop = 1'b0;
  logic [7:0] hold_cycles = 8'h0A;
  decode_s dec_in = '{CLS_PLAIN, 1'b1, 16'h0000, 16'h4000};
  logic bus_request_in, suspend_in, bus_grant_out, used_bus, bus_oe, seg_early, nonop_out;
  bus_cycle_s bus_out;
  op_state_e op_state;
  logic [WORD_W-1:0] flag_control_word;
  logic [ADDR_W-1:0] pc_out;
  int err_count = 0;
  int samples_checked = 0;

  // Clock at 40 MHz
  always #12.5 clk_sys = ~clk_sys;

  cpu_operating_state_control dut (.clk_sys(clk_sys), .reset(reset), .bus_request_in(bus_request_in),
    .suspend_in(suspend_in), .bus_grant_out(bus_grant_out), .irq_in(irq_in), .irq_mask_in(irq_mask_in),
    .dec_in(dec_in), .bus_out(bus_out), .bus_oe(bus_oe), .seg_early(seg_early), .op_state(op_state),
    .flag_control_word(flag_control_word), .pc_out(pc_out), .nonop_out(nonop_out));

  bus_master_model partner (.clk_sys(clk_sys), .want_bus(want_bus), .want_stop(want_stop),
    .hold_cycles(hold_cycles), .bus_grant_out(bus_grant_out), .bus_request_in(bus_request_in),
    .suspend_in(suspend_in), .used_bus(used_bus));

  // Inputs change a fixed delay after the rising edge
  task automatic tick();
    @(posedge clk_sys);
    #2;
  endtask : tick

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic wait_state(input op_state_e s, input string name);
    for (int i = 0; i < 300 && op_state !== s; i++) tick();
    check(name, 32'(op_state), 32'(s));
  endtask : wait_state

  task automatic wait_pc(input logic [ADDR_W-1:0] t, input string name);
    for (int i = 0; i < 300 && pc_out !== t; i++) tick();
    check(name, 32'(pc_out), 32'(t));
  endtask : wait_pc

  task automatic set_dec(input instr_class_e c, input logic [15:0] t, input logic [15:0] f);
    dec_in = '{c, 1'b1, t, f};
  endtask : set_dec

  task automatic t_reset_entry();
    check("nonop", 32'(nonop_out), 32'h1);
    check("flags_rst", 32'(flag_control_word), 32'(FLAGS_RESET));
    check("grant_rst", 32'(bus_grant_out), 32'h0);
    reset = 1'b0;
    wait_state(OP_RUN, "run_after_rst");
  endtask : t_reset_entry

  task automatic t_run_seq();
    logic [15:0] last;
    int fetches, refreshes, seg_hi;
    fetches = 0;
    refreshes = 0;
    seg_hi = 0;
    last = pc_out;
    for (int i = 0; i < 200; i++) begin
      tick();
      if (bus_out.kind === CYC_FETCH) fetches++;
      if (bus_out.kind === CYC_REFRESH) refreshes++;
      if (seg_early === 1'b1) seg_hi++;
      if (pc_out !== last && op_state === OP_RUN) check("pc_step", 32'(pc_out - last), 32'h2);
      last = pc_out;
    end
    check("fetch_seen", 32'(fetches > 0), 32'h1);
    check("refresh_due", 32'(refreshes > 0), 32'h1);
    check("seg_early_nonseg", 32'(seg_hi), 32'h0);
  endtask : t_run_seq

  task automatic t_branch_irq();
    int writes;
    writes = 0;
    set_dec(CLS_BRANCH, 16'h0100, 16'h4000);
    wait_pc(16'h0100, "branch_pc");
    set_dec(CLS_PLAIN, 16'h0000, 16'h4000);
    irq_mask_in = 1'b1;
    irq_in = 1'b1;
    for (int i = 0; i < 60; i++) begin
      tick();
      if (pc_out === INT_PC) check("masked_irq", 32'(pc_out), 32'hFFFF);
    end
    irq_mask_in = 1'b0;
    for (int i = 0; i < 300 && pc_out !== INT_PC; i++) begin
      tick();
      if (bus_out.kind === CYC_WRITE) writes++;
    end
    irq_in = 1'b0;
    check("irq_pc", 32'(pc_out), 32'(INT_PC));
    check("irq_flags", 32'(flag_control_word), 32'(EXC_FLAGS));
    check("status_saved", 32'(writes >= 2), 32'h1);
  endtask : t_branch_irq

  task automatic t_modes();
    int seg_hi;
    seg_hi = 0;
    set_dec(CLS_LOAD_PS, 16'h0200, 16'h0000);
    wait_pc(16'h0200, "ldps_pc");
    check("ldps_flags", 32'(flag_control_word), 32'h0);
    set_dec(CLS_PRIV, 16'h0000, 16'h0000);
    wait_pc(TRAP_PC, "priv_trap");
    set_dec(CLS_BRANCH, 16'h0300, 16'h4000);
    wait_pc(16'h0300, "br_back");
    set_dec(CLS_EXT, 16'h0000, 16'h0000);
    wait_pc(TRAP_PC, "ext_trap");
    set_dec(CLS_LOAD_PS, 16'h0400, 16'hC000);
    wait_pc(16'h0400, "seg_pc");
    for (int i = 0; i < 40; i++) begin
      tick();
      if (seg_early === 1'b1 && bus_out.kind === CYC_FETCH) seg_hi++;
    end
    check("seg_early", 32'(seg_hi > 0), 32'h1);
    set_dec(CLS_LOAD_PS, 16'h0500, 16'h4000);
    wait_pc(16'h0500, "nonseg_pc");
    set_dec(CLS_PLAIN, 16'h0000, 16'h4000);
  endtask : t_modes

  task automatic t_bus();
    want_bus = 1'b1;
    for (int i = 0; i < 100 && bus_grant_out !== 1'b1; i++) tick();
    check("disc_after_grant", 32'(op_state === OP_DISC), 32'h0);
    wait_state(OP_DISC, "disc");
    check("float", 32'(bus_oe), 32'h0);
    check("idle_bus", 32'(bus_out.kind), 32'(CYC_NONE));
    for (int i = 0; i < 100 && used_bus !== 1'b1; i++) tick();
    want_bus = 1'b0;
    wait_state(OP_RUN, "leave_disc");
    check("grant_drop", 32'(bus_grant_out), 32'h0);
  endtask : t_bus

  task automatic t_stop();
    logic [15:0] held;
    want_stop = 1'b1;
    wait_state(OP_STOP, "stop");
    held = pc_out;
    for (int i = 0; i < 20; i++) begin
      tick();
      if (bus_out.kind === CYC_FETCH) check("fetch_in_stop", 32'(bus_out.kind), 32'(CYC_REFRESH));
    end
    check("pc_frozen", 32'(pc_out), 32'(held));
    want_bus = 1'b1;
    wait_state(OP_DISC, "req_priority");
    for (int i = 0; i < 100 && used_bus !== 1'b1; i++) tick();
    want_bus = 1'b0;
    wait_state(OP_STOP, "back_to_stop");
    want_stop = 1'b0;
    wait_state(OP_RUN, "stop_exit");
  endtask : t_stop

  task automatic t_reset_mid(input logic bus, input op_state_e exp);
    want_stop = ~bus;
    want_bus = bus;
    reset = 1'b1;
    repeat (5) tick();
    check("nonop_mid", 32'(nonop_out), 32'h1);
    check("state_mid", 32'(op_state), 32'(OP_RESET));
    reset = 1'b0;
    wait_state(exp, "state_release");
    for (int i = 0; i < 100 && bus && used_bus !== 1'b1; i++) tick();
    want_stop = 1'b0;
    want_bus = 1'b0;
    wait_state(OP_RUN, "run_again");
  endtask : t_reset_mid

  task automatic complete_run();
    if (err_count == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : complete_run

  // Main sequence
  initial begin
    repeat (4) tick();
    t_reset_entry();
    t_run_seq();
    t_branch_irq();
    t_modes();
    t_bus();
    t_stop();
    t_reset_mid(1'b0, OP_STOP);
    t_reset_mid(1'b1, OP_DISC);
    complete_run();
  end

  // Watchdog against a hang
  initial begin
    #(25 * 20000);
    err_count++;
    complete_run();
  end
endmodule : tb_top
